// ---- ibad_decoder.sv ----
// Module: internal bus address decoder with vector address formation
`timescale 1ns/10ps
module ibad_decoder (
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic CLK_EN,
	input wire logic [23:0] ADDR,
	input wire logic [2:0] FUNCTION_CODE_LINES,
	input wire logic ADDR_STROBE,
	input wire logic REGISTER_BLOCK_MAP_BIT,
	input wire logic [1:0] SPACE_MODE,
	input wire logic VEC_REQ,
	input wire logic VEC_IS_RESET,
	input wire logic [7:0] VEC_NUM,
	input wire logic [23:0] VECTOR_TABLE_BASE,
	input wire logic THREE_STATE_CONTROL,
	output logic SEL_REG,
	output logic SEL_RSVD,
	output logic SEL_EXT,
	output logic SEL_DENY,
	output logic EXT_OE,
	output logic [2:0] EXT_SPACE,
	output logic [23:0] VEC_ADDR,
	output logic [2:0] VEC_FC,
	output logic VEC_VALID
);
	ibad_pkg::ibad_req_s req;
	ibad_pkg::ibad_sel_s sel_next;
	ibad_pkg::ibad_sel_s sel_reg;
	logic [2:0] space_next;
	logic [2:0] space_reg;
	logic in_blk;
	logic [5:0] page;
	logic [2:0] tsc_sync_reg;
	logic tsc_reg;

	assign req = '{addr: ADDR, fc: FUNCTION_CODE_LINES, strobe: ADDR_STROBE};
	assign page = req.addr[ibad_pkg::BLK_W-1 -: 6];
	// Block hit: top nibble must be map bit followed by 111
	assign in_blk = (req.addr[ibad_pkg::MAP_POS] == REGISTER_BLOCK_MAP_BIT) &&
		(req.addr[ibad_pkg::TAG_MSB:ibad_pkg::TAG_LSB] == ibad_pkg::BLK_TAG) &&
		(req.addr[19:ibad_pkg::BLK_W] == 8'hFF); // [RULE2] [RULE12]

	always_comb begin
		sel_next = '0;
		if (req.strobe) begin // [RULE13]
			if (in_blk && ibad_pkg::RSVD_PAGES[page]) begin
				sel_next.sel_rsvd = 1'b1; // [RULE9]
			end else if (in_blk && ibad_pkg::USED_PAGES[page]) begin
				if (ibad_pkg::SUPV_PAGES[page] && !req.fc[ibad_pkg::SUPV_BIT]) begin
					sel_next.deny = 1'b1; // [RULE10]
				end else begin
					sel_next.sel_reg = 1'b1;
				end
			end else begin
				sel_next.sel_ext = 1'b1; // [RULE9]
			end
		end
	end

	// Space code shown to outside decode for the chosen arrangement
	always_comb begin
		case (ibad_pkg::ibad_space_e'(SPACE_MODE))
			ibad_pkg::SP_SINGLE: space_next = 3'h0; // [RULE3]
			ibad_pkg::SP_SUPV_USER: space_next = {req.fc[2], 2'b00}; // [RULE4]
			ibad_pkg::SP_FOUR: space_next = req.fc; // [RULE5]
			default: space_next = 3'h0;
		endcase
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			sel_reg <= '0;
			space_reg <= 3'h0;
		end else if (CLK_EN) begin
			sel_reg <= sel_next;
			space_reg <= space_next;
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			tsc_sync_reg <= 3'h0;
			tsc_reg <= 1'b0;
		end else if (CLK_EN) begin
			tsc_sync_reg <= {tsc_sync_reg[1:0], THREE_STATE_CONTROL};
			if (tsc_sync_reg[1] == tsc_sync_reg[2]) begin
				tsc_reg <= tsc_sync_reg[2];
			end
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			VEC_ADDR <= 24'h00_0000;
			VEC_FC <= 3'h0;
			VEC_VALID <= 1'b0;
		end else if (CLK_EN) begin
			VEC_VALID <= VEC_REQ;
			if (VEC_REQ) begin
				if (VEC_IS_RESET) begin
					VEC_ADDR <= ibad_pkg::RESET_VEC_ADDR; // [RULE8]
					VEC_FC <= ibad_pkg::FC_SUPV_PROG; // [RULE6]
				end else begin
					VEC_ADDR <= VECTOR_TABLE_BASE + {14'h0000, VEC_NUM, 2'b00}; // [RULE7] [RULE8]
					VEC_FC <= ibad_pkg::FC_SUPV_DATA; // [RULE6]
				end
			end
		end
	end

	assign SEL_REG = sel_reg.sel_reg;
	assign SEL_RSVD = sel_reg.sel_rsvd;
	assign SEL_DENY = sel_reg.deny;
	assign SEL_EXT = sel_reg.sel_ext;
	assign EXT_OE = sel_reg.sel_ext && !tsc_reg; // [RULE11] [RULE1]
	assign EXT_SPACE = space_reg;
endmodule

// ---- ibad_decoder_tb_top.sv ----
// Testbench: scenarios for the bus address decoder
`timescale 1ns/10ps
module ibad_decoder_tb_top;
	logic MCLK = 0, RST_B = 0, CLK_EN = 1, ADDR_STROBE = 0, REGISTER_BLOCK_MAP_BIT = 0;
	logic VEC_REQ = 0, VEC_IS_RESET = 0, THREE_STATE_CONTROL = 0;
	logic SEL_REG, SEL_RSVD, SEL_EXT, SEL_DENY, EXT_OE, VEC_VALID;
	logic [23:0] ADDR = 0, VECTOR_TABLE_BASE = 0, VEC_ADDR;
	logic [2:0] FUNCTION_CODE_LINES = 3'h5, EXT_SPACE, VEC_FC;
	logic [1:0] SPACE_MODE = 0, bank;
	logic [7:0] VEC_NUM = 0;
	int n_mismatch = 0, compares = 0, cyc = 0;
	ibad_decoder DUT (.*);
	ibad_ext_mem u_mem (.EXT_SPACE(EXT_SPACE), .BANK(bank));
	initial forever #25 MCLK = ~MCLK;
	always @(posedge MCLK) if (++cyc > 2000) begin
		n_mismatch++;
		$display("mismatch at %0t: timeout", $time);
		end_sim;
	end
	task end_sim;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic ok);
		compares++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("mismatch at %0t: wrong output", $time);
		end
	endtask
	task acc(input logic [23:0] a, input logic [2:0] f);
		ADDR = a;
		FUNCTION_CODE_LINES = f;
		ADDR_STROBE = 1'b1;
		@(negedge MCLK);
	endtask
	task t_map;
		for (int m = 0; m < 2; m++) begin
			REGISTER_BLOCK_MAP_BIT = m[0];
			acc({m[0], 23'h7FFC00}, 3'h5);
			chk(SEL_REG);
			acc({!m[0], 23'h7FFC00}, 3'h5);
			chk(SEL_EXT);
		end
	endtask
	task t_hole;
		acc(24'hFFFA00, 3'h5);
		chk(SEL_RSVD && !EXT_OE);
		acc(24'hFFF500, 3'h5);
		chk(SEL_EXT && EXT_OE);
		acc(24'hFFF000, 3'h1);
		chk(SEL_DENY && !SEL_REG);
		ADDR_STROBE = 1'b0;
		@(negedge MCLK);
		chk({SEL_REG, SEL_RSVD, SEL_EXT, SEL_DENY} === 4'h0);
	endtask
	task t_space;
		for (int s = 0; s < 3; s++) for (int i = 0; i < 4; i++) begin
			SPACE_MODE = s[1:0];
			acc(24'h001000, {i[1], i[0], !i[0]});
			chk(bank === (s == 0 ? 2'h0 : s == 1 ? {i[1], 1'b0} : i[1:0]));
		end
	endtask
	task t_frz;
		SPACE_MODE = 2'h3;
		acc(24'h001000, 3'h6);
		chk(SEL_EXT && EXT_SPACE === 3'h0);
		CLK_EN = 1'b0;
		acc(24'hFFF000, 3'h5);
		chk(SEL_EXT && !SEL_REG && EXT_SPACE === 3'h0);
		CLK_EN = 1'b1;
		ADDR_STROBE = 1'b0;
		RST_B = 1'b0;
		@(negedge MCLK);
		chk({SEL_REG, SEL_RSVD, SEL_EXT, SEL_DENY, VEC_VALID} === 5'h00);
		RST_B = 1'b1;
		@(negedge MCLK);
		chk({SEL_REG, SEL_RSVD, SEL_EXT, SEL_DENY, EXT_OE} === 5'h00);
		acc(24'hFFF000, 3'h5);
		chk(SEL_REG && !SEL_DENY);
	endtask
	task t_vec;
		VECTOR_TABLE_BASE = 24'h001000;
		VEC_NUM = 8'h02;
		VEC_REQ = 1'b1;
		@(negedge MCLK);
		chk(VEC_VALID && VEC_ADDR === 24'h001008 && VEC_FC === 3'h5);
		VEC_IS_RESET = 1'b1;
		@(negedge MCLK);
		chk(VEC_VALID && VEC_ADDR === 24'h000000 && VEC_FC === 3'h6);
		VEC_REQ = 1'b0;
		THREE_STATE_CONTROL = 1'b1;
		acc(24'h001000, 3'h5);
		repeat (4) @(negedge MCLK);
		chk(SEL_EXT && !EXT_OE && !VEC_VALID);
	endtask
	initial begin
		repeat (8) @(negedge MCLK);
		RST_B = 1'b1;
		@(negedge MCLK);
		t_map;
		t_hole;
		t_space;
		t_frz;
		t_vec;
		end_sim;
	end
endmodule

// ---- ibad_ext_mem.sv ----
// Partner: external memory decode of the space code
`timescale 1ns/10ps
module ibad_ext_mem (
	input wire logic [2:0] EXT_SPACE,
	output logic [1:0] BANK
);
	assign BANK = EXT_SPACE[2:1];
endmodule

// ---- ibad_pkg.sv ----
// Package: constants and types for the internal bus address decoder
// Functional notes
// RULE1: Internal module bus carries 24-bit address and 16-bit data.
// RULE2: Register block recognised only when address bits 23..20 equal map bit then 111.
// RULE3: Single-space arrangement: outside decode ignores all function-code lines.
// RULE4: Two-space arrangement: outside decode uses only the supervisor line.
// RULE5: Four-space arrangement: outside decode uses all three function-code lines; ibad_ext_mem decodes only EXT_SPACE[2:1].
// RULE6: Vectors fetched from supervisor data space; reset vector from supervisor program space.
// RULE7: Vector address is vector table base plus vector offset.
// RULE8: Only reset vector location fixed; table elsewhere follows the vector table base.
// RULE9: Unused register-block addresses go external; reserved holes are never driven out.
// RULE10: User-space accesses to supervisor-only registers are denied.
// RULE11: Three-state control places every output driver in high impedance; here it only drops EXT_OE, after a synchronise-and-filter stage.
// RULE12: All module control registers form one 4-Kbyte block placed by the map bit.
// RULE13: At most one target select per cycle, qualified by address strobe.
package ibad_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int BLK_W = 12;
	localparam logic [2:0] BLK_TAG = 3'h7;
	localparam int TAG_LSB = 20;
	localparam int TAG_MSB = 22;
	localparam int MAP_POS = 23;
	localparam int PAGE_LSB = 6;
	localparam int PAGES = 64;
	localparam logic [63:0] USED_PAGES = 64'hFFFF_0000_0000_000F;
	localparam logic [63:0] RSVD_PAGES = 64'h0000_FF00_0000_0000;
	localparam logic [63:0] SUPV_PAGES = 64'h0000_0000_0000_0003;
	localparam logic [2:0] FC_USER_DATA = 3'h1;
	localparam logic [2:0] FC_USER_PROG = 3'h2;
	localparam logic [2:0] FC_SUPV_DATA = 3'h5;
	localparam logic [2:0] FC_SUPV_PROG = 3'h6;
	localparam int SUPV_BIT = 2;
	localparam logic [23:0] RESET_VEC_ADDR = 24'h00_0000;
	typedef struct packed {
		logic [23:0] addr;
		logic [2:0] fc;
		logic strobe;
	} ibad_req_s;
	typedef struct packed {
		logic sel_reg;
		logic sel_rsvd;
		logic sel_ext;
		logic deny;
	} ibad_sel_s;
	typedef enum logic [1:0] {
		SP_SINGLE = 2'b00,
		SP_SUPV_USER = 2'b01,
		SP_FOUR = 2'b10
	} ibad_space_e;
endpackage

// ---- ibad_properties.sv ----
// Checker: port properties of the bus address decoder
`timescale 1ns/10ps
module ibad_chk (
	input wire logic MCLK, RST_B, CLK_EN, ADDR_STROBE, REGISTER_BLOCK_MAP_BIT, VEC_REQ,
	input wire logic VEC_IS_RESET, THREE_STATE_CONTROL, SEL_REG, SEL_RSVD, SEL_EXT,
	input wire logic SEL_DENY, EXT_OE, VEC_VALID,
	input wire logic [23:0] ADDR, VECTOR_TABLE_BASE, VEC_ADDR,
	input wire logic [2:0] FUNCTION_CODE_LINES, VEC_FC,
	input wire logic [7:0] VEC_NUM
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	wire hit = ADDR_STROBE && CLK_EN;
	wire blk = hit && ADDR[23:20] == {REGISTER_BLOCK_MAP_BIT, 3'h7} && ADDR[19:12] == 8'hFF;
	wire vq = VEC_REQ && CLK_EN;
	sequence s_tsc; THREE_STATE_CONTROL [*5]; endsequence
	property p_reg; blk && ADDR[11:10] == 2'h3 |=> SEL_REG; endproperty
	property p_rsv; blk && ADDR[11:9] == 3'h5 |=> SEL_RSVD && !EXT_OE; endproperty
	property p_dny; blk && ADDR[11:7] == 5'h0 && !FUNCTION_CODE_LINES[2] |=> SEL_DENY; endproperty
	property p_one; $onehot0({SEL_REG, SEL_RSVD, SEL_EXT, SEL_DENY}); endproperty
	property p_idl; !ADDR_STROBE && CLK_EN |=> !(SEL_REG || SEL_RSVD || SEL_EXT); endproperty
	property p_vec; vq && !VEC_IS_RESET |=> VEC_VALID && VEC_FC == 3'h5
		&& VEC_ADDR == $past(VECTOR_TABLE_BASE) + {$past(VEC_NUM), 2'h0}; endproperty
	property p_rv; vq && VEC_IS_RESET |=> VEC_VALID && VEC_FC == 3'h6 && VEC_ADDR == 24'h0; endproperty
	property p_tsc; s_tsc |-> !EXT_OE; endproperty
	a_reg: assert property (p_reg) else $error("no reg select");
	a_rsv: assert property (p_rsv) else $error("hole went out");
	a_dny: assert property (p_dny) else $error("no deny");
	a_one: assert property (p_one) else $error("two selects");
	a_idl: assert property (p_idl) else $error("select idle");
	a_vec: assert property (p_vec) else $error("bad vector");
	a_rv: assert property (p_rv) else $error("bad reset vec");
	a_tsc: assert property (p_tsc) else $error("driver on");
endmodule
bind ibad_decoder ibad_chk u_chk (.*);
